// *** src/ccd_pkg.sv ***
// constants and types shared by the instruction execute unit and its stack
package ccd_pkg;
  localparam int CCD_PC_W = 11;
  localparam int CCD_DATA_W = 8;
  localparam int CCD_STACK_DEPTH = 2;
  localparam logic [3:0] CCD_OPC_CALL = 4'h9;
  localparam logic [6:0] CCD_OPC_ZERO_FILE = 7'h03;
  localparam logic [11:0] CCD_WORD_ZERO_ACC = 12'h040;
  localparam logic [11:0] CCD_WORD_KICK = 12'h004;
  localparam logic [5:0] CCD_OPC_INVERT = 6'h09;
  localparam logic [5:0] CCD_OPC_DECREMENT = 6'h03;
  localparam int CCD_CALL_POS = 8;
  localparam int CCD_ZFILE_POS = 5;
  localparam int CCD_DFILE_POS = 6;
  localparam int CCD_DEST_BIT = 5;
  localparam logic [CCD_PC_W-1:0] CCD_PC_RESET = 11'h000;
  localparam logic [CCD_DATA_W-1:0] CCD_W_RESET = 8'h00;
  localparam logic CCD_EXPIRED_RESET = 1'b1;
  localparam logic CCD_SLEEP_RESET = 1'b1;
  localparam logic [CCD_DATA_W-1:0] CCD_ZERO_BYTE = 8'h00;

  typedef enum logic [1:0] {
    CCD_EXEC = 2'b00,
    CCD_FLUSH = 2'b01
  } ccd_state_type;
endpackage

// *** src/ccd_stack_if.sv ***
// carrier between the execute unit and its return-address stack
`timescale 1ns/100ps
`default_nettype none
interface ccd_stack_if
  import ccd_pkg::*;
#(
  parameter int PC_W = CCD_PC_W
);
  logic push;
  logic [PC_W-1:0] pushData;
  logic [PC_W-1:0] stackHead;
  modport core (output push, output pushData, input stackHead);
  modport lifo (input push, input pushData, output stackHead);
endinterface
`default_nettype wire

// *** src/ccd_return_stack.sv ***
// fixed-depth return-address stack, newest entry at the head
`timescale 1ns/100ps
`default_nettype none
module ccd_return_stack
  import ccd_pkg::*;
#(
  parameter int PC_W = CCD_PC_W,
  parameter int DEPTH = CCD_STACK_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  ccd_stack_if.lifo stk
);
  typedef struct packed {
    logic [DEPTH-1:0][PC_W-1:0] entries;
  } ccd_stack_state_type;

  ccd_stack_state_type st_q;
  ccd_stack_state_type st_d;

  // overflow drops the oldest entry
  always_comb begin
    st_d = st_q;
    if (stk.push) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        st_d.entries[i] = st_q.entries[i-1];
      end
      st_d.entries[0] = stk.pushData;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign stk.stackHead = st_q.entries[0];

  AST_STACK_PUSH: assert property (@(posedge sys_clk) disable iff (!rst_b)
    stk.push |=> stk.stackHead == $past(stk.pushData))
    else $error("stack head does not hold pushed address");
endmodule
`default_nettype wire

// *** src/ccd_exec_unit.sv ***
// decode and execute of call, clear, watchdog kick, invert and decrement
`timescale 1ns/100ps
`default_nettype none
module ccd_exec_unit
  import ccd_pkg::*;
#(
  parameter int PC_W = CCD_PC_W,
  parameter int DATA_W = CCD_DATA_W,
  parameter int STACK_DEPTH = CCD_STACK_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic instrValid,
  input wire logic [11:0] instrWord,
  input wire logic discardNext,
  input wire logic [1:0] statusPage,
  input wire logic prescalerOnWatchdog,
  input wire logic expiredClear,
  input wire logic sleepClear,
  input wire logic [DATA_W-1:0] fileRdData,
  output logic [4:0] fileRdAddr,
  output logic fileWrEn,
  output logic [4:0] fileWrAddr,
  output logic [DATA_W-1:0] fileWrData,
  output logic [DATA_W-1:0] workingReg,
  output logic zeroFlag,
  output logic watchdog_expired_flag,
  output logic sleep_entered_flag,
  output logic watchdogCounterClear,
  output logic prescalerClear,
  output logic [PC_W-1:0] progCounter,
  output logic [PC_W-1:0] stack_head,
  output logic execIdle
);
  typedef struct packed {
    ccd_state_type state;
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] w;
    logic zero;
    logic expired;
    logic sleep;
    logic wrEn;
    logic [4:0] wrAddr;
    logic [DATA_W-1:0] wrData;
    logic kick;
    logic presClr;
  } ccd_exec_state_type;

  ccd_exec_state_type st_q;
  ccd_exec_state_type st_d;
  ccd_stack_if #(.PC_W(PC_W)) stk ();

  logic execNow;
  logic isCall;
  logic isZeroFile;
  logic isZeroAcc;
  logic isKick;
  logic isInvert;
  logic isDecrement;
  logic destFile;
  logic [DATA_W-1:0] aluResult;
  logic [PC_W-1:0] pcNext;

  // in the flush slot the fetched word is never decoded
  assign execNow = instrValid && (st_q.state == CCD_EXEC);
  assign isCall = execNow && (instrWord[11:CCD_CALL_POS] == CCD_OPC_CALL);
  assign isZeroFile = execNow && (instrWord[11:CCD_ZFILE_POS] == CCD_OPC_ZERO_FILE);
  assign isZeroAcc = execNow && (instrWord == CCD_WORD_ZERO_ACC);
  assign isKick = execNow && (instrWord == CCD_WORD_KICK);
  assign isInvert = execNow && (instrWord[11:CCD_DFILE_POS] == CCD_OPC_INVERT);
  assign isDecrement = execNow && (instrWord[11:CCD_DFILE_POS] == CCD_OPC_DECREMENT);
  assign destFile = instrWord[CCD_DEST_BIT];
  assign pcNext = PC_W'(st_q.pc + 1'b1);

  always_comb begin
    aluResult = CCD_ZERO_BYTE;
    if (isInvert) begin
      aluResult = ~fileRdData;
    end else if (isDecrement) begin
      aluResult = DATA_W'(fileRdData - 1'b1);
    end
  end

  assign stk.push = isCall;
  assign stk.pushData = pcNext;

  always_comb begin
    st_d = st_q;
    st_d.wrEn = 1'b0;
    st_d.kick = 1'b0;
    st_d.presClr = 1'b0;
    // a flush slot holds across bubbles so the discarded word is the next real fetch
    if (instrValid) begin
      st_d.state = CCD_EXEC;
      st_d.pc = pcNext;
    end
    if (instrValid && (st_q.state == CCD_EXEC) && discardNext) begin
      st_d.state = CCD_FLUSH;
    end
    if (isCall) begin
      // flags untouched; the flush slot gives the second cycle
      st_d.pc = {statusPage, 1'b0, instrWord[7:0]};
      st_d.state = CCD_FLUSH;
    end
    if (isZeroFile) begin
      st_d.wrEn = 1'b1;
      st_d.wrAddr = instrWord[4:0];
      st_d.wrData = CCD_ZERO_BYTE;
      st_d.zero = 1'b1;
    end
    if (isZeroAcc) begin
      st_d.w = CCD_ZERO_BYTE;
      st_d.zero = 1'b1;
    end
    if (isInvert || isDecrement) begin
      st_d.zero = (aluResult == CCD_ZERO_BYTE);
      if (destFile) begin
        st_d.wrEn = 1'b1;
        st_d.wrAddr = instrWord[4:0];
        st_d.wrData = aluResult;
      end else begin
        st_d.w = aluResult;
      end
    end
    // kick sets the flags and wins over a clear in the same cycle
    if (expiredClear) begin
      st_d.expired = 1'b0;
    end
    if (sleepClear) begin
      st_d.sleep = 1'b0;
    end
    if (isKick) begin
      st_d.kick = 1'b1;
      st_d.expired = 1'b1;
      st_d.sleep = 1'b1;
      st_d.presClr = prescalerOnWatchdog;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q.state <= CCD_EXEC;
      st_q.pc <= CCD_PC_RESET;
      st_q.w <= CCD_W_RESET;
      st_q.zero <= 1'b0;
      st_q.expired <= CCD_EXPIRED_RESET;
      st_q.sleep <= CCD_SLEEP_RESET;
      st_q.wrEn <= 1'b0;
      st_q.wrAddr <= 5'h00;
      st_q.wrData <= CCD_ZERO_BYTE;
      st_q.kick <= 1'b0;
      st_q.presClr <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  ccd_return_stack #(.PC_W(PC_W), .DEPTH(STACK_DEPTH)) u_stack (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .stk(stk)
  );

  assign fileRdAddr = instrWord[4:0];
  assign fileWrEn = st_q.wrEn;
  assign fileWrAddr = st_q.wrAddr;
  assign fileWrData = st_q.wrData;
  assign workingReg = st_q.w;
  assign zeroFlag = st_q.zero;
  assign watchdog_expired_flag = st_q.expired;
  assign sleep_entered_flag = st_q.sleep;
  assign watchdogCounterClear = st_q.kick;
  assign prescalerClear = st_q.presClr;
  assign progCounter = st_q.pc;
  assign stack_head = stk.stackHead;
  assign execIdle = (st_q.state == CCD_FLUSH);

  AST_CALL_PUSH: assert property (@(posedge sys_clk) disable iff (!rst_b)
    isCall |=> stack_head == PC_W'($past(progCounter) + 1'b1))
    else $error("call did not push return address");

  AST_CALL_PC: assert property (@(posedge sys_clk) disable iff (!rst_b)
    isCall |=> progCounter == {$past(statusPage), 1'b0, $past(instrWord[7:0])})
    else $error("call target address wrong");

  AST_CALL_TWO_CYCLE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    isCall |=> execIdle && $stable(zeroFlag) && !fileWrEn ##1 (!execIdle || !$past(instrValid)))
    else $error("call not two cycles or flags changed");

  AST_ZERO_FILE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    isZeroFile |=> fileWrEn && fileWrData == 8'h00 && fileWrAddr == $past(instrWord[4:0]) && zeroFlag)
    else $error("zero_file_reg wrong");

  AST_ZERO_ACC: assert property (@(posedge sys_clk) disable iff (!rst_b)
    isZeroAcc |=> workingReg == 8'h00 && zeroFlag && !fileWrEn)
    else $error("zero_accumulator wrong");

  AST_KICK: assert property (@(posedge sys_clk) disable iff (!rst_b)
    isKick |=> watchdogCounterClear && watchdog_expired_flag && sleep_entered_flag
      ##1 (!watchdogCounterClear || $past(isKick)))
    else $error("watchdog_kick effects wrong");

  AST_PRESCALER: assert property (@(posedge sys_clk) disable iff (!rst_b)
    prescalerClear |-> $past(isKick) && $past(prescalerOnWatchdog))
    else $error("prescaler cleared while not on watchdog");

  AST_INVERT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    isInvert && !destFile |=> workingReg == ~$past(fileRdData) && zeroFlag == ($past(fileRdData) == 8'hFF))
    else $error("invert_file_reg wrong");

  AST_DECREMENT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    isDecrement && destFile |=> fileWrEn && fileWrData == 8'($past(fileRdData) - 1'b1)
      && zeroFlag == ($past(fileRdData) == 8'h01))
    else $error("decrement_file_reg wrong");

  AST_DISCARD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    execIdle && instrValid |=> !fileWrEn && !watchdogCounterClear && !prescalerClear && !execIdle
      && $stable(workingReg) && $stable(zeroFlag) && stack_head == $past(stack_head)
      && progCounter == PC_W'($past(progCounter) + 1'b1))
    else $error("discarded instruction executed");
endmodule
`default_nettype wire

// *** verification/ccd_exec_unit_tb.sv ***
// self-checking random bench for the call, clear, kick, invert and decrement unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ccd_pkg::*;
  localparam int N_OPS = 3000;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic instrValid = 1'b0;
  logic [11:0] instrWord = 12'h000;
  logic discardNext = 1'b0;
  logic [1:0] statusPage = 2'h0;
  logic prescalerOnWatchdog = 1'b0;
  logic expiredClear = 1'b0;
  logic sleepClear = 1'b0;
  logic [7:0] fileRdData = 8'h00;
  logic [4:0] fileRdAddr, fileWrAddr;
  logic fileWrEn, zeroFlag, watchdog_expired_flag, sleep_entered_flag;
  logic watchdogCounterClear, prescalerClear, execIdle;
  logic [7:0] fileWrData, workingReg;
  logic [10:0] progCounter, stack_head;
  int failures = 0;
  int n_checks = 0;
  logic [10:0] mPc, mStk;
  logic [7:0] mW, mWrData, r;
  logic [4:0] mWrAddr;
  logic mZ, mExp, mSlp, mIdle, mWrEn, mWdc, mPsc;

  ccd_exec_unit i_ccd_exec_unit (.sys_clk(sys_clk), .rst_b(rst_b), .instrValid(instrValid),
    .instrWord(instrWord), .discardNext(discardNext), .statusPage(statusPage),
    .prescalerOnWatchdog(prescalerOnWatchdog), .expiredClear(expiredClear), .sleepClear(sleepClear),
    .fileRdData(fileRdData), .fileRdAddr(fileRdAddr), .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr),
    .fileWrData(fileWrData), .workingReg(workingReg), .zeroFlag(zeroFlag),
    .watchdog_expired_flag(watchdog_expired_flag), .sleep_entered_flag(sleep_entered_flag),
    .watchdogCounterClear(watchdogCounterClear), .prescalerClear(prescalerClear),
    .progCounter(progCounter), .stack_head(stack_head), .execIdle(execIdle));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // uniform pick of opcode kind and operand
  function automatic logic [11:0] gen_word(input int kind, input logic [7:0] v);
    case (kind)
      0: return {4'h9, v};
      1: return {7'h03, v[4:0]};
      2: return 12'h040;
      3: return 12'h004;
      4: return {6'h09, v[5:0]};
      5: return {6'h03, v[5:0]};
      default: return {4'h8, v};
    endcase
  endfunction

  // next model state from the inputs currently driven
  task automatic step;
    mWrEn = 1'b0;
    mWdc = 1'b0;
    mPsc = 1'b0;
    if (expiredClear) mExp = 1'b0;
    if (sleepClear) mSlp = 1'b0;
    if (instrValid && mIdle) begin
      mPc = mPc + 11'h001;
      mIdle = 1'b0;
    end else if (instrValid) begin
      mPc = mPc + 11'h001;
      mIdle = discardNext;
      if (instrWord[11:8] == 4'h9) begin
        mStk = mPc;
        mPc = {statusPage, 1'b0, instrWord[7:0]};
        mIdle = 1'b1;
      end
      if (instrWord[11:5] == 7'h03) begin
        mWrEn = 1'b1;
        mWrAddr = instrWord[4:0];
        mWrData = 8'h00;
        mZ = 1'b1;
      end
      if (instrWord == 12'h040) begin
        mW = 8'h00;
        mZ = 1'b1;
      end
      if (instrWord == 12'h004) begin
        mWdc = 1'b1;
        mExp = 1'b1;
        mSlp = 1'b1;
        mPsc = prescalerOnWatchdog;
      end
      r = (instrWord[11:6] == 6'h09) ? ~fileRdData : fileRdData - 8'h01;
      if (instrWord[11:6] == 6'h09 || instrWord[11:6] == 6'h03) begin
        mZ = (r == 8'h00);
        if (instrWord[5]) begin
          mWrEn = 1'b1;
          mWrAddr = instrWord[4:0];
          mWrData = r;
        end else
          mW = r;
      end
    end
  endtask

  initial begin
    int sel;
    void'($urandom(14020));
    {mPc, mStk, mW, mZ, mIdle} = '0;
    mExp = 1'b1;
    mSlp = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < N_OPS; i++) begin
      instrValid = ($urandom % 8) != 0;
      instrWord = gen_word($urandom % 7, 8'($urandom));
      discardNext = ($urandom % 8) == 0;
      statusPage = 2'($urandom);
      prescalerOnWatchdog = 1'($urandom);
      expiredClear = ($urandom % 8) == 0;
      sleepClear = ($urandom % 8) == 0;
      sel = $urandom % 4;
      // zero results of invert and decrement come from 8'hFF and 8'h01
      fileRdData = (sel == 0) ? 8'h01 : (sel == 1) ? 8'hFF : (sel == 2) ? 8'h00 : 8'($urandom);
      #1 check(fileRdAddr, instrWord[4:0]);
      step();
      @(posedge sys_clk);
      #1 check(progCounter, mPc);
      check(stack_head, mStk);
      check(execIdle, mIdle);
      check(workingReg, mW);
      check(zeroFlag, mZ);
      check({watchdog_expired_flag, sleep_entered_flag}, {mExp, mSlp});
      check(watchdogCounterClear, mWdc);
      check(prescalerClear, mPsc);
      check(fileWrEn, mWrEn);
      if (mWrEn) begin
        check({fileWrAddr, fileWrData}, {mWrAddr, mWrData});
      end
    end
    complete_run();
  end

  // twice the expected run length before giving up
  initial begin
    #(N_OPS * 8 * 2 + 1000);
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
